// ==== include/cie_pkg.sv ====
// Package with constants and types for the instruction execute block.
package cie_pkg;

  localparam logic [15:0] SHORT_BASE = 16'hFE00;
  localparam logic [15:0] SP_RESET = 16'hFF00;
  localparam logic [7:0] PSW_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [1:0] FIXED_AREA_TOP = 2'h1;
  localparam logic [6:0] CLK_LOGIC = 7'h03;
  localparam logic [6:0] CLK_WORD_IMM = 7'h04;
  localparam logic [6:0] CLK_MUL = 7'h2F;
  localparam logic [6:0] CLK_DIV = 7'h4A;
  localparam logic [6:0] CLK_SHIFT_BASE = 7'h03;
  localparam logic [6:0] CLK_ADJ = 7'h03;
  localparam logic [6:0] CLK_REL_TAKEN = 7'h04;
  localparam logic [6:0] CLK_REL_SKIP = 7'h02;
  localparam logic [6:0] CLK_BT_TAKEN = 7'h07;
  localparam logic [6:0] CLK_BT_SKIP = 7'h05;
  localparam logic [6:0] CLK_TC_TAKEN = 7'h0D;
  localparam logic [6:0] CLK_TC_SKIP = 7'h07;
  localparam logic [6:0] CLK_DB_TAKEN = 7'h06;
  localparam logic [6:0] CLK_DB_SKIP = 7'h04;
  localparam logic [6:0] CLK_CALL_INT = 7'h0B;
  localparam logic [6:0] CLK_CALL_EXT = 7'h0F;
  localparam logic [6:0] CLK_RETI_INT = 7'h0F;
  localparam logic [6:0] CLK_RETI_EXT = 7'h15;
  localparam logic [6:0] CLK_IMASK = 7'h02;
  localparam logic [6:0] CLK_SP_HIGH = 7'h01;
  localparam int PSW_CARRY = 0;
  localparam int PSW_HALF = 4;
  localparam int PSW_NULL = 6;
  localparam int PSW_IME = 7;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPS = 8'h04;
  localparam logic [7:0] ADDR_WORD = 8'h08;
  localparam logic [7:0] ADDR_GO = 8'h0C;
  localparam logic [7:0] ADDR_ACC = 8'h10;
  localparam logic [7:0] ADDR_REG = 8'h14;
  localparam logic [7:0] ADDR_PC = 8'h18;
  localparam logic [7:0] ADDR_SP = 8'h1C;
  localparam logic [7:0] ADDR_STAT = 8'h20;
  localparam logic [7:0] ADDR_PSW = 8'h24;
  localparam logic [7:0] ADDR_STACK = 8'h28;

  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_SUBWB = 5'h01, OP_AND = 5'h02, OP_OR = 5'h03, OP_XOR = 5'h04,
    OP_CMP = 5'h05, OP_WADD = 5'h06, OP_WSUB = 5'h07, OP_WCMP = 5'h08, OP_MULU = 5'h09,
    OP_MULS = 5'h0A, OP_DIVU = 5'h0B, OP_SHR = 5'h0C, OP_SHL = 5'h0D, OP_ROR = 5'h0E,
    OP_ROL = 5'h0F, OP_WSHR = 5'h10, OP_WSHL = 5'h11, OP_ADJA = 5'h12, OP_ADJS = 5'h13,
    OP_BCY = 5'h14, OP_BTRUE = 5'h15, OP_TEST_CLEAR_BRANCH = 5'h16, OP_DECREMENT_BRANCH_NONZERO = 5'h17, OP_CALL = 5'h18,
    OP_FIXED_AREA_CALL = 5'h19, OP_RETI = 5'h1A, OP_EI = 5'h1B, OP_DI = 5'h1C, OP_SHORT = 5'h1D
  } cie_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_DONE = 2'b11
  } cie_state_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cie_apb_out_t;

  typedef struct packed {
    cie_state_t st;
    cie_op_t op;
    logic [7:0] src;
    logic [2:0] cnt;
    logic ext_mem;
    logic [15:0] word_op;
    logic [15:0] acc;
    logic [7:0] reg8;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] program_status_word;
    logic [23:0] stack;
    logic [15:0] addr;
    logic [6:0] wait_cnt;
    logic [31:0] cycles;
    cie_apb_out_t apb;
  } cie_state_all_t;

endpackage

// ==== hdl/cie_execute.sv ====
// Execution unit for part of an 8-bit core instruction set, driven over APB.
// Behaviour
// - Subtract with borrow removes source and carry, writes back, sets null, half and carry.
// - Short indirect address is FE00H plus the 8-bit index.
// - AND, OR, XOR write the result and change only the null flag.
// - Compare subtracts without storing and sets the three arithmetic flags.
// - Word add and subtract use the wide accumulator; immediate form 4 clocks.
// - Unsigned multiply splits product: upper 16 to accumulator, lower 8 to register; 47 clocks.
// - Signed multiply uses signed accumulator and magnitude register, same split, 47 clocks.
// - Unsigned divide gives quotient in accumulator, remainder in register, 74 clocks.
// - Byte shifts repeat n times, zero fill, carry out, half cleared, 3+2n clocks.
// - Rotates repeat n times, wrapped bit to carry, only carry changes, 3+2n clocks.
// - Word shifts act over 16 bits like byte shifts, 3+3n clocks.
// - Decimal adjust after add or subtract sets null and half, sets carry only on an upper-digit adjust, in 3 clocks.
// - Bit-true branch goes to address plus 3 plus offset; 7 taken, 5 not.
// - Test-clear branch also clears the set bit; 13 taken, 7 not.
// - Decrement then branch if nonzero, address plus 3; 6 taken, 4 not.
// - Call pushes address plus 3 below stack pointer, subtracts 2, jumps; 11 or 15.
// - Fixed-area call pushes return, forces PC bits 12-11 to 01, loads low 11 bits.
// - Interrupt return pops PC low, PC high, status word; stack pointer plus 3.
// - Stack pointer changes in its upper byte add extra clocks.
// - Unmask and mask set and clear the master enable in 2 clocks.
// - Every clock count equals that many system clock periods.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none

module cie_execute
  import cie_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy
);

  cie_state_all_t s;
  cie_state_all_t next_s;

  // Flags of an 8-bit subtraction: null, half and carry.
  function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] d;
    logic [4:0] h;
    d = {1'b0, a} - {1'b0, b} - {8'h00, ci};
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
    sub8 = {d[7:0], d[7:0] == 8'h00, h[4], d[8]};
  endfunction

  // Cycles added when the stack pointer upper byte moves.
  function automatic logic [6:0] sp_extra(input logic [15:0] a, input logic [15:0] b);
    sp_extra = (a[15:8] != b[15:8]) ? CLK_SP_HIGH : 7'h00;
  endfunction

  logic apb_access;
  logic apb_first;
  logic apb_take;
  logic [10:0] sres;
  logic [16:0] wsum;
  logic [23:0] prod;
  logic [15:0] mag;
  logic [15:0] new_sp;
  logic [15:0] rel_pc;
  logic [7:0] adj;
  logic [7:0] dec_v;
  logic [2:0] n;
  logic bit_v;
  logic ac_w;

  always_comb begin
    apb_access = psel && penable;
    apb_first = apb_access && !s.apb.pready;
    apb_take = apb_access && s.apb.pready;
    n = s.cnt;
    bit_v = s.src[s.word_op[2:0]];
    dec_v = s.reg8 - 8'h01;
    sres = 11'h000;
    wsum = 17'h00000;
    prod = 24'h000000;
    mag = 16'h0000;
    new_sp = s.sp;
    rel_pc = s.pc + {{8{s.src[7]}}, s.src};
    adj = 8'h00;
    ac_w = 1'b0;
    next_s = s;
    // One wait state; the transfer completes on the edge that sees pready, so it is never taken twice.
    next_s.apb.pready = apb_first;
    next_s.apb.pslverr = 1'b0;
    next_s.apb.prdata = 32'h00000000;
    next_s.cycles = s.cycles + 32'h00000001;
    if (apb_first && !pwrite) begin
      if (paddr == ADDR_CTRL) begin
        next_s.apb.prdata = {8'h00, s.src, 3'h0, s.ext_mem, 1'b0, s.cnt, 3'h0, s.op};
      end else if (paddr == ADDR_WORD) begin
        next_s.apb.prdata = {16'h0000, s.word_op};
      end else if (paddr == ADDR_ACC) begin
        next_s.apb.prdata = {16'h0000, s.acc};
      end else if (paddr == ADDR_REG) begin
        next_s.apb.prdata = {24'h000000, s.reg8};
      end else if (paddr == ADDR_PC) begin
        next_s.apb.prdata = {16'h0000, s.pc};
      end else if (paddr == ADDR_SP) begin
        next_s.apb.prdata = {16'h0000, s.sp};
      end else if (paddr == ADDR_STAT) begin
        next_s.apb.prdata = {s.cycles[21:0], 1'b0, s.wait_cnt, s.st};
      end else if (paddr == ADDR_PSW) begin
        next_s.apb.prdata = {8'h00, s.addr, s.program_status_word};
      end else if (paddr == ADDR_STACK) begin
        next_s.apb.prdata = {8'h00, s.stack};
      end else if (paddr != ADDR_OPS && paddr != ADDR_GO) begin
        next_s.apb.pslverr = 1'b1;
      end
    end
    if (apb_first && pwrite) begin
      // State registers are frozen while an instruction runs, so its operands stay coherent.
      if ((s.st != ST_IDLE && paddr != ADDR_STAT) || paddr == ADDR_OPS) begin
        next_s.apb.pslverr = 1'b1;
      end else if (paddr > ADDR_STACK || paddr[1:0] != 2'h0) begin
        next_s.apb.pslverr = 1'b1;
      end
    end
    // A write lands only on the completing edge, and only if it was not refused.
    if (apb_take && pwrite && !s.apb.pslverr) begin
      if (paddr == ADDR_CTRL) begin
        next_s.op = cie_op_t'(pwdata[4:0]);
        next_s.cnt = pwdata[10:8];
        next_s.ext_mem = pwdata[12];
        next_s.src = pwdata[23:16];
      end else if (paddr == ADDR_WORD) begin
        next_s.word_op = pwdata[15:0];
      end else if (paddr == ADDR_ACC) begin
        next_s.acc = pwdata[15:0];
      end else if (paddr == ADDR_REG) begin
        next_s.reg8 = pwdata[7:0];
      end else if (paddr == ADDR_PC) begin
        next_s.pc = pwdata[15:0];
      end else if (paddr == ADDR_SP) begin
        next_s.sp = pwdata[15:0];
      end else if (paddr == ADDR_PSW) begin
        next_s.program_status_word = pwdata[7:0];
      end else if (paddr == ADDR_STACK) begin
        next_s.stack = pwdata[23:0];
      end else if (paddr == ADDR_GO) begin
        next_s.st = ST_RUN;
        next_s.wait_cnt = 7'h00;
      end else if (paddr == ADDR_STAT) begin
        next_s.cycles = 32'h00000000;
      end
    end
    case (s.st)
      ST_RUN: begin
        next_s.st = ST_DONE;
        case (s.op)
          OP_SUBWB, OP_CMP: begin
            sres = sub8(s.acc[7:0], s.src, (s.op == OP_SUBWB) && s.program_status_word[PSW_CARRY]);
            if (s.op == OP_SUBWB) begin
              next_s.acc[7:0] = sres[10:3];
            end
            next_s.program_status_word[PSW_NULL] = sres[2];
            next_s.program_status_word[PSW_HALF] = sres[1];
            next_s.program_status_word[PSW_CARRY] = sres[0];
            next_s.wait_cnt = CLK_LOGIC;
          end
          OP_AND, OP_OR, OP_XOR: begin
            if (s.op == OP_AND) begin
              adj = s.acc[7:0] & s.src;
            end else if (s.op == OP_OR) begin
              adj = s.acc[7:0] | s.src;
            end else begin
              adj = s.acc[7:0] ^ s.src;
            end
            next_s.acc[7:0] = adj;
            next_s.program_status_word[PSW_NULL] = adj == 8'h00;
            next_s.wait_cnt = CLK_LOGIC;
          end
          OP_WADD, OP_WSUB, OP_WCMP: begin
            if (s.op == OP_WADD) begin
              wsum = {1'b0, s.acc} + {1'b0, s.word_op};
              ac_w = ({1'b0, s.acc[3:0]} + {1'b0, s.word_op[3:0]}) > 5'h0F;
            end else begin
              wsum = {1'b0, s.acc} - {1'b0, s.word_op};
              ac_w = s.acc[3:0] < s.word_op[3:0];
            end
            if (s.op != OP_WCMP) begin
              next_s.acc = wsum[15:0];
            end
            next_s.program_status_word[PSW_NULL] = wsum[15:0] == 16'h0000;
            next_s.program_status_word[PSW_HALF] = ac_w;
            next_s.program_status_word[PSW_CARRY] = wsum[16];
            next_s.wait_cnt = (s.op == OP_WCMP) ? CLK_LOGIC : CLK_WORD_IMM;
          end
          OP_MULU, OP_MULS: begin
            mag = (s.op == OP_MULS && s.acc[15]) ? (16'h0000 - s.acc) : s.acc;
            prod = mag * s.reg8;
            if (s.op == OP_MULS && s.acc[15]) begin
              prod = 24'h000000 - prod;
            end
            next_s.acc = prod[23:8];
            next_s.reg8 = prod[7:0];
            next_s.wait_cnt = CLK_MUL;
          end
          OP_DIVU: begin
            // Division by zero is left undefined; the all-ones quotient keeps the datapath quiet.
            if (s.reg8 != 8'h00) begin
              next_s.acc = s.acc / {8'h00, s.reg8};
              next_s.reg8 = 8'(s.acc % {8'h00, s.reg8});
            end else begin
              next_s.acc = 16'hFFFF;
            end
            next_s.wait_cnt = CLK_DIV;
          end
          OP_SHR, OP_SHL, OP_ROR, OP_ROL: begin
            adj = s.reg8;
            for (int i = 0; i < 7; i++) begin
              if (3'(i) < n) begin
                if (s.op == OP_SHR || s.op == OP_ROR) begin
                  next_s.program_status_word[PSW_CARRY] = adj[0];
                  adj = {(s.op == OP_ROR) && adj[0], adj[7:1]};
                end else begin
                  next_s.program_status_word[PSW_CARRY] = adj[7];
                  adj = {adj[6:0], (s.op == OP_ROL) && adj[7]};
                end
              end
            end
            next_s.reg8 = adj;
            if (s.op == OP_SHR || s.op == OP_SHL) begin
              next_s.program_status_word[PSW_HALF] = 1'b0;
              next_s.program_status_word[PSW_NULL] = adj == 8'h00;
            end
            next_s.wait_cnt = CLK_SHIFT_BASE + {3'h0, n, 1'b0};
          end
          OP_WSHR, OP_WSHL: begin
            mag = s.acc;
            for (int i = 0; i < 7; i++) begin
              if (3'(i) < n) begin
                if (s.op == OP_WSHR) begin
                  next_s.program_status_word[PSW_CARRY] = mag[0];
                  mag = {1'b0, mag[15:1]};
                end else begin
                  next_s.program_status_word[PSW_CARRY] = mag[15];
                  mag = {mag[14:0], 1'b0};
                end
              end
            end
            next_s.acc = mag;
            next_s.program_status_word[PSW_HALF] = 1'b0;
            next_s.program_status_word[PSW_NULL] = mag == 16'h0000;
            next_s.wait_cnt = CLK_SHIFT_BASE + {4'h0, n} + {3'h0, n, 1'b0};
          end
          OP_ADJA, OP_ADJS: begin
            if (s.program_status_word[PSW_HALF] || s.acc[3:0] > 4'h9) begin
              adj[3:0] = 4'h6;
            end
            if (s.program_status_word[PSW_CARRY] || s.acc[7:0] > 8'h99) begin
              adj[7:4] = 4'h6;
              next_s.program_status_word[PSW_CARRY] = 1'b1;
            end
            dec_v = (s.op == OP_ADJA) ? s.acc[7:0] + adj : s.acc[7:0] - adj;
            next_s.acc[7:0] = dec_v;
            next_s.program_status_word[PSW_NULL] = dec_v == 8'h00;
            next_s.program_status_word[PSW_HALF] = (s.op == OP_ADJA) ? (s.acc[3:0] > 4'h9) : (adj[3:0] != 4'h0);
            next_s.wait_cnt = CLK_ADJ;
          end
          OP_BCY: begin
            next_s.pc = s.program_status_word[PSW_CARRY] ? rel_pc + 16'h0002 : s.pc + 16'h0002;
            next_s.wait_cnt = s.program_status_word[PSW_CARRY] ? CLK_REL_TAKEN : CLK_REL_SKIP;
          end
          OP_BTRUE, OP_TEST_CLEAR_BRANCH: begin
            // Source byte holds the tested byte and word_op[15:8] the displacement.
            rel_pc = s.pc + 16'h0003 + {{8{s.word_op[15]}}, s.word_op[15:8]};
            next_s.pc = bit_v ? rel_pc : s.pc + 16'h0003;
            if (s.op == OP_TEST_CLEAR_BRANCH) begin
              if (bit_v) begin
                next_s.src[s.word_op[2:0]] = 1'b0;
              end
              next_s.wait_cnt = bit_v ? CLK_TC_TAKEN : CLK_TC_SKIP;
            end else begin
              next_s.wait_cnt = bit_v ? CLK_BT_TAKEN : CLK_BT_SKIP;
            end
          end
          OP_DECREMENT_BRANCH_NONZERO: begin
            next_s.reg8 = dec_v;
            next_s.pc = (dec_v != 8'h00) ? rel_pc + 16'h0003 : s.pc + 16'h0003;
            next_s.wait_cnt = (dec_v != 8'h00) ? CLK_DB_TAKEN : CLK_DB_SKIP;
          end
          OP_CALL, OP_FIXED_AREA_CALL: begin
            new_sp = s.sp - 16'h0002;
            next_s.sp = new_sp;
            if (s.op == OP_CALL) begin
              next_s.stack[15:0] = s.pc + 16'h0003;
              next_s.pc = s.word_op;
            end else begin
              next_s.stack[15:0] = s.pc + 16'h0002;
              next_s.pc = {s.pc[15:13], FIXED_AREA_TOP, s.word_op[10:0]};
            end
            next_s.addr = new_sp;
            next_s.wait_cnt = (s.ext_mem ? CLK_CALL_EXT : CLK_CALL_INT) + sp_extra(s.sp, new_sp);
          end
          OP_RETI: begin
            new_sp = s.sp + 16'h0003;
            next_s.pc = s.stack[15:0];
            next_s.program_status_word = s.stack[23:16];
            next_s.sp = new_sp;
            next_s.addr = s.sp;
            next_s.wait_cnt = (s.ext_mem ? CLK_RETI_EXT : CLK_RETI_INT) + sp_extra(s.sp, new_sp);
          end
          OP_EI, OP_DI: begin
            next_s.program_status_word[PSW_IME] = (s.op == OP_EI);
            next_s.pc = s.pc + 16'h0001;
            next_s.wait_cnt = CLK_IMASK;
          end
          OP_SHORT: begin
            next_s.addr = SHORT_BASE + {8'h00, s.src};
            next_s.wait_cnt = CLK_LOGIC;
          end
          default: begin
            next_s.wait_cnt = CLK_IMASK;
          end
        endcase
        // The RUN cycle itself is the first of the count.
        next_s.wait_cnt = next_s.wait_cnt - 7'h01;
      end
      ST_DONE: begin
        if (s.wait_cnt <= 7'h01) begin
          next_s.st = ST_IDLE;
          next_s.wait_cnt = 7'h00;
        end else begin
          next_s.wait_cnt = s.wait_cnt - 7'h01;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.op <= OP_NOP;
      s.sp <= SP_RESET;
      s.pc <= PC_RESET;
      s.program_status_word <= PSW_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.apb.prdata;
  assign pready = s.apb.pready;
  assign pslverr = s.apb.pslverr;
  assign busy = s.st != ST_IDLE;

endmodule

`default_nettype wire

// ==== test/cie_execute_checker.sv ====
// Port-level assertions for the instruction execute block.
`timescale 1ns/1ns
`default_nettype none
module cie_execute_checker
  import cie_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busy
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready did not follow the access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  a_ready_needs_access: assert property (pready |-> $past(psel && penable) && psel)
    else $error("pready without an access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside a response");
  a_unmapped_err: assert property (psel && penable && !pready && paddr > ADDR_STACK |=> pslverr)
    else $error("unmapped access not refused");
  a_busy_refuse: assert property (psel && penable && !pready && pwrite && busy && paddr != ADDR_STAT |=> pslverr)
    else $error("write during busy not refused");
  a_go_starts: assert property (psel && penable && !pready && pwrite && paddr == ADDR_GO && !busy |=> ##[0:1] busy)
    else $error("start did not raise busy");
  a_busy_min: assert property ($rose(busy) |-> busy ##1 busy)
    else $error("busy shorter than two cycles");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:80] !busy)
    else $error("busy exceeded the longest count");
  a_read_ok: assert property (psel && penable && !pready && !pwrite && paddr <= ADDR_STACK && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped read refused");
endmodule
bind cie_execute cie_execute_checker chk_i (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
`default_nettype wire

// ==== test/cie_execute_test.sv ====
// Self-checking testbench for the instruction execute block.
`timescale 1ns/1ns
`default_nettype none
module cie_execute_test;
  import cie_pkg::*;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, busy, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata, busy_cnt;
  int mismatches, check_count;
  cie_execute uut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Counting sampled busy cycles measures the instruction length independent of the start latency.
  always @(posedge mclk) begin
    if (reset || (psel && penable && pwrite && pready && paddr == ADDR_GO)) begin
      busy_cnt <= 32'h0;
    end else if (busy === 1'b1) begin
      busy_cnt <= busy_cnt + 32'h1;
    end
  end
  task finish_test;
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cmp(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) mismatches++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    cmp(rdata & m, e);
  endtask
  task go(input cie_op_t op, input logic [2:0] n, input logic ext, input logic [7:0] src, input logic [15:0] w);
    apb(1'b1, ADDR_CTRL, {8'h00, src, 3'h0, ext, 1'b0, n, 3'h0, op});
    apb(1'b1, ADDR_WORD, {16'h0000, w});
    apb(1'b1, ADDR_GO, 32'h1);
  endtask
  task fin(input logic [6:0] clocks);
    int k;
    for (k = 0; k < 200; k++) begin
      @(posedge mclk);
      if (busy === 1'b0 && busy_cnt != 0) break;
    end
    cmp(busy_cnt, {25'h0, clocks});
  endtask
  task alu(input cie_op_t op, input logic [2:0] n, input logic [7:0] src, input logic [15:0] w,
      input logic [6:0] clocks, input logic [15:0] ai, input logic [7:0] ri, pi, input logic [15:0] ax,
      input logic [7:0] rx, px);
    apb(1'b1, ADDR_ACC, {16'h0000, ai});
    apb(1'b1, ADDR_REG, {24'h000000, ri});
    apb(1'b1, ADDR_PSW, {24'h000000, pi});
    go(op, n, 1'b0, src, w);
    fin(clocks);
    chk(ADDR_ACC, 32'h0000FFFF, {16'h0000, ax});
    chk(ADDR_REG, 32'h000000FF, {24'h000000, rx});
    chk(ADDR_PSW, 32'h000000FF, {24'h000000, px});
  endtask
  task br(input cie_op_t op, input logic ext, input logic [7:0] src, input logic [15:0] w, pci, spi,
      input logic [7:0] pi, input logic [23:0] si, input logic [6:0] clocks, input logic [15:0] pcx);
    apb(1'b1, ADDR_PC, {16'h0000, pci});
    apb(1'b1, ADDR_SP, {16'h0000, spi});
    apb(1'b1, ADDR_PSW, {24'h000000, pi});
    apb(1'b1, ADDR_STACK, {8'h00, si});
    go(op, 3'h0, ext, src, w);
    fin(clocks);
    chk(ADDR_PC, 32'h0000FFFF, {16'h0000, pcx});
  endtask
  initial begin
    repeat (30000) @(posedge mclk);
    mismatches++;
    finish_test;
  end
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    check_count = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    chk(ADDR_SP, 32'h0000FFFF, 32'h0000FF00);
    alu(OP_SUBWB, 3'h0, 8'h05, 16'h0, 7'h03, 16'h0010, 8'h00, 8'h01, 16'h000A, 8'h00, 8'h10);
    alu(OP_AND, 3'h0, 8'h0F, 16'h0, 7'h03, 16'h00F0, 8'h00, 8'h11, 16'h0000, 8'h00, 8'h51);
    alu(OP_OR, 3'h0, 8'h0F, 16'h0, 7'h03, 16'h00F0, 8'h00, 8'h51, 16'h00FF, 8'h00, 8'h11);
    alu(OP_XOR, 3'h0, 8'hFF, 16'h0, 7'h03, 16'h00FF, 8'h00, 8'h00, 16'h0000, 8'h00, 8'h40);
    alu(OP_CMP, 3'h0, 8'h06, 16'h0, 7'h03, 16'h0005, 8'h00, 8'h40, 16'h0005, 8'h00, 8'h11);
    alu(OP_WADD, 3'h0, 8'h00, 16'h0001, 7'h04, 16'hFFFF, 8'h00, 8'h00, 16'h0000, 8'h00, 8'h51);
    alu(OP_WSUB, 3'h0, 8'h00, 16'h0001, 7'h04, 16'h0000, 8'h00, 8'h40, 16'hFFFF, 8'h00, 8'h11);
    alu(OP_MULU, 3'h0, 8'h00, 16'h0, 7'h2F, 16'h1234, 8'h10, 8'h00, 16'h0123, 8'h40, 8'h00);
    alu(OP_MULS, 3'h0, 8'h00, 16'h0, 7'h2F, 16'hFFFE, 8'h03, 8'h00, 16'hFFFF, 8'hFA, 8'h00);
    alu(OP_DIVU, 3'h0, 8'h00, 16'h0, 7'h4A, 16'h0064, 8'h07, 8'h00, 16'h000E, 8'h02, 8'h00);
    alu(OP_SHR, 3'h1, 8'h00, 16'h0, 7'h05, 16'h0000, 8'h81, 8'h10, 16'h0000, 8'h40, 8'h01);
    alu(OP_SHL, 3'h7, 8'h00, 16'h0, 7'h11, 16'h0000, 8'h03, 8'h00, 16'h0000, 8'h80, 8'h01);
    alu(OP_ROR, 3'h1, 8'h00, 16'h0, 7'h05, 16'h0000, 8'h01, 8'h50, 16'h0000, 8'h80, 8'h51);
    alu(OP_ROL, 3'h2, 8'h00, 16'h0, 7'h07, 16'h0000, 8'h80, 8'h01, 16'h0000, 8'h02, 8'h00);
    alu(OP_WSHR, 3'h1, 8'h00, 16'h0, 7'h06, 16'h0001, 8'h00, 8'h10, 16'h0000, 8'h00, 8'h41);
    alu(OP_WSHL, 3'h3, 8'h00, 16'h0, 7'h0C, 16'h8000, 8'h00, 8'h01, 16'h0000, 8'h00, 8'h40);
    alu(OP_ADJA, 3'h0, 8'h00, 16'h0, 7'h03, 16'h000F, 8'h00, 8'h00, 16'h0015, 8'h00, 8'h10);
    alu(OP_ADJS, 3'h0, 8'h00, 16'h0, 7'h03, 16'h000F, 8'h00, 8'h10, 16'h0009, 8'h00, 8'h10);
    alu(OP_EI, 3'h0, 8'h00, 16'h0, 7'h02, 16'h0000, 8'h00, 8'h00, 16'h0000, 8'h00, 8'h80);
    alu(OP_DI, 3'h0, 8'h00, 16'h0, 7'h02, 16'h0000, 8'h00, 8'h80, 16'h0000, 8'h00, 8'h00);
    go(OP_SHORT, 3'h0, 1'b0, 8'hFF, 16'h0);
    fin(7'h03);
    chk(ADDR_PSW, 32'h00FFFF00, 32'h00FEFF00);
    br(OP_BCY, 1'b0, 8'hFE, 16'h0, 16'h1000, 16'hFE10, 8'h01, 24'h0, 7'h04, 16'h1000);
    br(OP_BCY, 1'b0, 8'hFE, 16'h0, 16'h1000, 16'hFE10, 8'h00, 24'h0, 7'h02, 16'h1002);
    br(OP_BTRUE, 1'b0, 8'h04, 16'hF002, 16'h1000, 16'hFE10, 8'h00, 24'h0, 7'h07, 16'h0FF3);
    br(OP_BTRUE, 1'b0, 8'h00, 16'hF002, 16'h1000, 16'hFE10, 8'h00, 24'h0, 7'h05, 16'h1003);
    br(OP_TEST_CLEAR_BRANCH, 1'b0, 8'h81, 16'h0507, 16'h1000, 16'hFE10, 8'h00, 24'h0, 7'h0D, 16'h1008);
    chk(ADDR_CTRL, 32'h00FF0000, 32'h00010000);
    br(OP_TEST_CLEAR_BRANCH, 1'b0, 8'h7F, 16'h0507, 16'h1000, 16'hFE10, 8'h00, 24'h0, 7'h07, 16'h1003);
    apb(1'b1, ADDR_REG, 32'h2);
    br(OP_DECREMENT_BRANCH_NONZERO, 1'b0, 8'h10, 16'h0, 16'h1000, 16'hFE10, 8'h00, 24'h0, 7'h06, 16'h1013);
    chk(ADDR_REG, 32'h000000FF, 32'h1);
    br(OP_DECREMENT_BRANCH_NONZERO, 1'b0, 8'h10, 16'h0, 16'h1000, 16'hFE10, 8'h00, 24'h0, 7'h04, 16'h1003);
    br(OP_CALL, 1'b0, 8'h00, 16'h2345, 16'h1000, 16'hFE10, 8'h00, 24'h0, 7'h0B, 16'h2345);
    chk(ADDR_SP, 32'h0000FFFF, 32'h0000FE0E);
    chk(ADDR_STACK, 32'h0000FFFF, 32'h00001003);
    br(OP_CALL, 1'b1, 8'h00, 16'h2345, 16'h1000, 16'hFF00, 8'h00, 24'h0, 7'h10, 16'h2345);
    br(OP_FIXED_AREA_CALL, 1'b0, 8'h00, 16'h0234, 16'h1000, 16'hFE10, 8'h00, 24'h0, 7'h0B, 16'h0A34);
    chk(ADDR_STACK, 32'h0000FFFF, 32'h00001002);
    br(OP_RETI, 1'b0, 8'h00, 16'h0, 16'h1000, 16'hFE0E, 8'h00, 24'h912345, 7'h0F, 16'h2345);
    chk(ADDR_SP, 32'h0000FFFF, 32'h0000FE11);
    chk(ADDR_PSW, 32'h000000FF, 32'h00000091);
    br(OP_RETI, 1'b1, 8'h00, 16'h0, 16'h1000, 16'hFEFF, 8'h00, 24'h002345, 7'h16, 16'h2345);
    apb(1'b1, ADDR_ACC, 32'h64);
    apb(1'b1, ADDR_REG, 32'h7);
    go(OP_DIVU, 3'h0, 1'b0, 8'h00, 16'h0);
    apb(1'b1, ADDR_ACC, 32'h5555);
    cmp({31'h0, rerr}, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    cmp({31'h0, rerr}, 32'h0);
    fin(7'h4A);
    chk(ADDR_ACC, 32'h0000FFFF, 32'h0000000E);
    apb(1'b0, 8'h2C, 32'h0);
    cmp({31'h0, rerr}, 32'h1);
    finish_test;
  end
endmodule
`default_nettype wire
